//--- rcsw_defs.svh
// Constant definitions for the redundant reference clock switch.
`ifndef RCSW_DEFS_SVH
`define RCSW_DEFS_SVH

// ----------------------------------------------------------------------
// Bus geometry and register map
// ----------------------------------------------------------------------
`define RCSW_AW         12
`define RCSW_DW         32
`define RCSW_ADDR_CTRL  12'h000
`define RCSW_ADDR_STAT  12'h004

// ----------------------------------------------------------------------
// Control register fields and reset value
// ----------------------------------------------------------------------
`define RCSW_CTRL_W     4
`define RCSW_CTRL_SEL   0
`define RCSW_CTRL_HOLD  1
`define RCSW_CTRL_DIVN  2
`define RCSW_CTRL_INITN 3
`define RCSW_CTRL_RST   4'hC

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define RCSW_STAT_W     4
`define RCSW_STAT_ACT   0
`define RCSW_STAT_F0    1
`define RCSW_STAT_F1    2
`define RCSW_STAT_PRI   3

// ----------------------------------------------------------------------
// Synchronisers, references and output divider
// ----------------------------------------------------------------------
`define RCSW_SYNC_W     3
`define RCSW_SYNC_MID   1
`define RCSW_SYNC_LAST  2
`define RCSW_NREF       2
`define RCSW_NOUT       6
`define RCSW_DIV_W      2
`define RCSW_DIV_LAST   2'h1
`define RCSW_REF_A      1'b0

`endif

//--- rcsw_pkg.sv
// Types shared by the redundant reference clock switch.
package rcsw_pkg;
	// Selection mode: automatic switching or held by the select input.
	typedef enum logic [0:0] {
		ST_AUTO   = 1'b0,
		ST_MANUAL = 1'b1
	} rcsw_state_e;
endpackage

//--- rcsw_mon_if.sv
// Carrier between the switch core and one reference monitor.
interface rcsw_mon_if;
	logic fb_rise; // One-cycle pulse on each filtered feedback rise.
	logic clear;   // One-cycle pulse that restarts the monitor.
	logic fail;    // Registered failure flag.
	logic lvl;     // Filtered level of the reference input.
	modport mon (input fb_rise, input clear, output fail, output lvl);
	modport ctl (output fb_rise, output clear, input fail, input lvl);
endinterface

//--- rcsw_ref_monitor.sv
// Failure monitor for one reference clock input.
`include "rcsw_defs.svh"

module rcsw_ref_monitor (
	input  wire logic  i_mclk,
	input  wire logic  i_sys_rst,
	input  wire logic  i_ref_pin,
	rcsw_mon_if.mon    mon
);
	logic [`RCSW_SYNC_W-1:0] sync_reg;
	logic                    lvl_reg;
	logic                    seen_reg;
	logic                    fail_reg;
	wire                     agree;
	wire                     edge_now;

	// A change counts only once the last two stages agree.
	assign agree    = sync_reg[`RCSW_SYNC_LAST] == sync_reg[`RCSW_SYNC_MID];
	assign edge_now = agree && (sync_reg[`RCSW_SYNC_LAST] != lvl_reg);
	assign mon.fail = fail_reg;
	assign mon.lvl  = lvl_reg;

	// Three-stage synchroniser and glitch filter for the pin.
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			sync_reg <= '0;
			lvl_reg  <= 1'b0;
		end else begin
			sync_reg <= {sync_reg[`RCSW_SYNC_W-2:0], i_ref_pin};
			if (agree)
				lvl_reg <= sync_reg[`RCSW_SYNC_LAST];
		end
	end

	// One feedback period with no edge marks the input as failed.
	// An edge in the same cycle as the feedback rise still counts.
	// A restart counts as an edge, so the partial window after it never flags.
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst || mon.clear) begin
			seen_reg <= 1'b1;
			fail_reg <= 1'b0;
		end else if (mon.fb_rise) begin
			seen_reg <= 1'b0;
			fail_reg <= !(seen_reg || edge_now);
		end else if (edge_now) begin
			seen_reg <= 1'b1;
		end
	end
endmodule // rcsw_ref_monitor

//--- rcsw_top.sv
// Top level of the redundant reference clock switch.
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`include "rcsw_defs.svh"
// Functional notes
// - Exactly one reference feeds the PLL.
// - Select input high picks reference B initially.
// - Active flag low for A, high for B.
// - Init falling edge records the primary reference.
// - Init falling edge clears both fail flags.
// - No toggle for a feedback period means failure.
// - Each input drives its own fail flag.
// - Fail flags track inputs, recover without init.
// - Manual hold keeps the selected clock always.
// - Manual select change switches reference and flag.
// - Hold low by default enables automatic switching.
// - Auto switch only when the other is good.
// - Active flag follows an automatic switch.
// - Stay on secondary while it stays good.
// - Secondary failing returns to a good primary.
// - Divider reset holds true low, inverted high.
// - Divider reset high by default, dividers run.

module rcsw_top (
	input  wire logic                 i_mclk,
	input  wire logic                 i_sys_rst,
	input  wire logic                 i_ref_clock_a,
	input  wire logic                 i_ref_clock_b,
	input  wire logic                 i_feedback_clk,
	input  wire logic                 i_psel,
	input  wire logic                 i_penable,
	input  wire logic                 i_pwrite,
	input  wire logic [`RCSW_AW-1:0]  i_paddr,
	input  wire logic [`RCSW_DW-1:0]  i_pwdata,
	output logic                      o_pready,
	output logic [`RCSW_DW-1:0]       o_prdata,
	output logic                      o_pslverr,
	output logic                      o_pll_ref,
	output logic                      o_active_ref_flag,
	output logic                      o_ref0_fail_flag,
	output logic                      o_ref1_fail_flag,
	output logic [`RCSW_NOUT-1:0]     o_true_clock_out,
	output logic [`RCSW_NOUT-1:0]     o_inverted_clock_out
);
	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic [`RCSW_SYNC_W-1:0]  fb_sync_reg;
	logic                     fb_lvl_reg;
	logic [`RCSW_CTRL_W-1:0]  ctrl_reg;
	logic [`RCSW_DW-1:0]      prdata_reg;
	logic                     slverr_reg;
	logic [`RCSW_DW-1:0]      rd_data_w;
	rcsw_pkg::rcsw_state_e    state_reg;
	rcsw_pkg::rcsw_state_e    state_next;
	logic                     active_reg;
	logic                     active_next;
	logic                     primary_reg;
	logic                     pll_ref_reg;
	logic [`RCSW_DIV_W-1:0]   div_cnt_reg;
	logic                     q_reg;
	logic                     qn_reg;
	logic [`RCSW_NREF-1:0]    fail_w;
	logic [`RCSW_NREF-1:0]    lvl_w;
	wire  [`RCSW_NREF-1:0]    ref_pins;
	wire                      fb_agree;
	wire                      fb_rise;
	wire                      setup_ph;
	wire                      access_ph;
	wire                      hit_ctrl;
	wire                      hit_stat;
	wire                      wr_ctrl;
	wire                      init_fall;
	wire                      sel;
	wire                      hold;
	wire                      div_run_n;
	wire                      init_n;
	wire                      act_fail;
	wire                      alt_fail;
	wire                      sw_ok;
	wire                      pll_ref_next;
	wire                      ref_rise;

	// Picks the bit of a two-reference vector that belongs to one input.
	function automatic logic pick(input logic [`RCSW_NREF-1:0] v, input logic idx);
		pick = (idx == `RCSW_REF_A) ? v[0] : v[1];
	endfunction

	// ------------------------------------------------------------------
	// Feedback clock sampling
	// ------------------------------------------------------------------
	// The feedback clock is a pin; it is filtered like the references.
	assign fb_agree = fb_sync_reg[`RCSW_SYNC_LAST] == fb_sync_reg[`RCSW_SYNC_MID];
	assign fb_rise  = fb_agree && fb_sync_reg[`RCSW_SYNC_LAST] && !fb_lvl_reg;

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			fb_sync_reg <= '0;
			fb_lvl_reg  <= 1'b0;
		end else begin
			fb_sync_reg <= {fb_sync_reg[`RCSW_SYNC_W-2:0], i_feedback_clk};
			if (fb_agree)
				fb_lvl_reg <= fb_sync_reg[`RCSW_SYNC_LAST];
		end
	end

	// ------------------------------------------------------------------
	// Reference monitors
	// ------------------------------------------------------------------
	// One monitor per input, each with its own fail flag.
	rcsw_mon_if mon_if [`RCSW_NREF] ();
	assign ref_pins = {i_ref_clock_b, i_ref_clock_a};

	genvar g;
	generate
		for (g = 0; g < `RCSW_NREF; g++) begin : g_mon
			assign mon_if[g].fb_rise = fb_rise;
			assign mon_if[g].clear   = init_fall;
			assign fail_w[g]         = mon_if[g].fail;
			assign lvl_w[g]          = mon_if[g].lvl;
			rcsw_ref_monitor u_mon (
				.i_mclk    (i_mclk),
				.i_sys_rst (i_sys_rst),
				.i_ref_pin (ref_pins[g]),
				.mon       (mon_if[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------------
	// Zero wait states; read data is captured in the setup cycle.
	assign setup_ph  = i_psel && !i_penable;
	assign access_ph = i_psel && i_penable;
	assign hit_ctrl  = i_paddr == `RCSW_ADDR_CTRL;
	assign hit_stat  = i_paddr == `RCSW_ADDR_STAT;
	assign wr_ctrl   = access_ph && i_pwrite && hit_ctrl;
	assign o_pready  = 1'b1;
	assign o_prdata  = prdata_reg;
	assign o_pslverr = slverr_reg;

	// Read multiplexer; unmapped addresses read as zero.
	always_comb begin
		rd_data_w = '0;
		if (hit_ctrl) begin
			rd_data_w[`RCSW_CTRL_W-1:0] = ctrl_reg;
		end else if (hit_stat) begin
			rd_data_w[`RCSW_STAT_ACT] = active_reg;
			rd_data_w[`RCSW_STAT_F0]  = fail_w[0];
			rd_data_w[`RCSW_STAT_F1]  = fail_w[1];
			rd_data_w[`RCSW_STAT_PRI] = primary_reg;
		end
	end

	// Bus answer registers, loaded once per transfer at setup.
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			prdata_reg <= '0;
			slverr_reg <= 1'b0;
		end else if (setup_ph) begin
			prdata_reg <= i_pwrite ? '0 : rd_data_w;
			slverr_reg <= !(hit_ctrl || hit_stat);
		end
	end

	// Control register; the reset value mirrors the pin pulls.
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst)
			ctrl_reg <= `RCSW_CTRL_RST;
		else if (wr_ctrl)
			ctrl_reg <= i_pwdata[`RCSW_CTRL_W-1:0];
	end

	// ------------------------------------------------------------------
	// Reference selection
	// ------------------------------------------------------------------
	assign sel       = ctrl_reg[`RCSW_CTRL_SEL];
	assign hold      = ctrl_reg[`RCSW_CTRL_HOLD];
	assign div_run_n = ctrl_reg[`RCSW_CTRL_DIVN];
	assign init_n    = ctrl_reg[`RCSW_CTRL_INITN];
	// Only a written high-to-low change is an event, not a steady low.
	assign init_fall = wr_ctrl && init_n && !i_pwdata[`RCSW_CTRL_INITN];
	assign act_fail  = pick(fail_w, active_reg);
	assign alt_fail  = pick(fail_w, !active_reg);
	assign sw_ok     = act_fail && !alt_fail;

	// Mode machine and next active reference.
	always_comb begin
		state_next  = state_reg;
		active_next = active_reg;
		case (state_reg)
			rcsw_pkg::ST_MANUAL: begin
				active_next = sel;
				if (!hold)
					state_next = rcsw_pkg::ST_AUTO;
			end
			rcsw_pkg::ST_AUTO: begin
				if (hold) begin
					state_next  = rcsw_pkg::ST_MANUAL;
					active_next = sel;
				end else if (init_fall) begin
					active_next = sel;
				end else if (sw_ok) begin
					active_next = !active_reg;
				end
			end
			default: begin
				state_next = rcsw_pkg::ST_AUTO;
			end
		endcase
	end

	// The active flag is the selection register itself, so it never lags.
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			state_reg   <= rcsw_pkg::ST_AUTO;
			active_reg  <= `RCSW_REF_A;
			primary_reg <= `RCSW_REF_A;
		end else begin
			state_reg  <= state_next;
			active_reg <= active_next;
			if (init_fall)
				primary_reg <= sel;
		end
	end

	assign o_active_ref_flag = active_reg;
	assign o_ref0_fail_flag  = fail_w[0];
	assign o_ref1_fail_flag  = fail_w[1];

	// ------------------------------------------------------------------
	// Reference path and output divider
	// ------------------------------------------------------------------
	// Registered mux so a switch cannot merge both references.
	assign pll_ref_next = pick(lvl_w, active_reg);
	assign ref_rise     = pll_ref_next && !pll_ref_reg;

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst)
			pll_ref_reg <= 1'b0;
		else
			pll_ref_reg <= pll_ref_next;
	end

	// Divider held in reset while the divider reset bit is low.
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst || !div_run_n) begin
			div_cnt_reg <= '0;
			q_reg       <= 1'b0;
			qn_reg      <= 1'b1;
		end else if (ref_rise) begin
			if (div_cnt_reg == `RCSW_DIV_LAST) begin
				div_cnt_reg <= '0;
				q_reg       <= !q_reg;
				qn_reg      <= !qn_reg;
			end else begin
				div_cnt_reg <= div_cnt_reg + 1'b1;
			end
		end
	end

	assign o_pll_ref            = pll_ref_reg;
	assign o_true_clock_out     = {`RCSW_NOUT{q_reg}};
	assign o_inverted_clock_out = {`RCSW_NOUT{qn_reg}};

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_sys_rst);

	wire auto_step = (state_reg == rcsw_pkg::ST_AUTO) && !hold && !init_fall;

	a_manual_follows_sel: assert property (
		$past(hold, 2) && $past(hold) |-> active_reg == $past(sel))
		else $error("manual hold did not follow the select bit");
	a_init_sets_primary: assert property (
		init_fall |=> primary_reg == $past(sel) && active_reg == $past(sel))
		else $error("init event did not record the selected reference");
	a_init_clears_flags: assert property (
		init_fall |=> !o_ref0_fail_flag && !o_ref1_fail_flag)
		else $error("init event did not clear the fail flags");
	a_auto_switch_over: assert property (
		auto_step && act_fail && !alt_fail |=> o_active_ref_flag != $past(active_reg))
		else $error("automatic switch to a good input did not happen");
	a_both_fail_keep: assert property (
		auto_step && act_fail && alt_fail |=> $stable(o_active_ref_flag))
		else $error("selection moved while both inputs failed");
	a_good_ref_stays: assert property (
		auto_step && !act_fail |=> $stable(o_active_ref_flag))
		else $error("selection moved away from a good reference");
	a_div_reset_hold: assert property (
		!div_run_n |=> o_true_clock_out == '0 && o_inverted_clock_out == '1)
		else $error("outputs not held while dividers are reset");
	a_pll_ref_source: assert property (
		##1 o_pll_ref == $past(pick(lvl_w, active_reg)))
		else $error("PLL reference is not the selected input");

	c_auto_switch: cover property (auto_step && sw_ok ##1 o_active_ref_flag);
	c_both_failed: cover property (auto_step && act_fail && alt_fail);
	c_init_event:  cover property (init_fall ##1 primary_reg);
endmodule // rcsw_top

//--- rcsw_ref_src.sv
// Behavioural model of the two reference sources and the feedback clock.
module rcsw_ref_src (
	input  wire logic i_run_a,
	input  wire logic i_run_b,
	input  wire logic i_stuck_a,
	input  wire logic i_stuck_b,
	output logic      o_ref_a,
	output logic      o_ref_b,
	output logic      o_fb
);
	timeunit 1ns;
	timeprecision 1ps;
	logic tog_a = 1'b0;
	logic tog_b = 1'b0;
	logic fb    = 1'b0;
	// Sources stay slow enough to be sampled; B is offset so the edges never coincide.
	initial begin
		forever #20 tog_a = ~tog_a;
	end
	initial begin
		#7;
		forever #20 tog_b = ~tog_b;
	end
	initial begin
		forever #40 fb = ~fb;
	end
	// A stopped source sits stuck at a level, which is the failure the block must see.
	assign o_ref_a = i_run_a ? tog_a : i_stuck_a;
	assign o_ref_b = i_run_b ? tog_b : i_stuck_b;
	assign o_fb    = fb;
endmodule // rcsw_ref_src

//--- rcsw_tb_top.sv
// Self-checking testbench of the redundant reference clock switch.
`include "rcsw_defs.svh"
module rcsw_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk, rst, psel, penable, pwrite, pready, pslverr, pll_ref, act, f0, f1;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [5:0]  tq, iq;
	logic        run_a, run_b, stk_a, stk_b, ref_a, ref_b, fb, s, ra, rb, exp_act, err;
	logic [1:0]  steps [5] = '{2'b01, 2'b11, 2'b10, 2'b00, 2'b10};
	int          n_errors = 0;
	int          n_tests = 0;
	int          np, nt;
	rcsw_top DUT (.i_mclk(mclk), .i_sys_rst(rst), .i_ref_clock_a(ref_a),
		.i_ref_clock_b(ref_b), .i_feedback_clk(fb), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
		.o_prdata(prdata), .o_pslverr(pslverr), .o_pll_ref(pll_ref),
		.o_active_ref_flag(act), .o_ref0_fail_flag(f0), .o_ref1_fail_flag(f1),
		.o_true_clock_out(tq), .o_inverted_clock_out(iq));
	rcsw_ref_src u_src (.i_run_a(run_a), .i_run_b(run_b), .i_stuck_a(stk_a),
		.i_stuck_b(stk_b), .o_ref_a(ref_a), .o_ref_b(ref_b), .o_fb(fb));
	// ----------------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------------
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One APB transfer; the request is held until pready is seen at a rising edge.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int k;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge mclk);
			if (pready === 1'b1) break;
		end
		if (k == 20) begin
			n_errors++;
			give_verdict();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic logic [31:0] ctl(input logic sel, hold, divn, initn);
		return {28'h0000000, initn, divn, hold, sel};
	endfunction
	function automatic logic [31:0] stat(input logic a, x0, x1, pri);
		return {28'h0000000, pri, x1, x0, a};
	endfunction
	// Automatic mode leaves a failed reference only for a good one.
	function automatic logic next_act(input logic cur, man, sel, x0, x1);
		if (man) return sel;
		if ((cur ? x1 : x0) && !(cur ? x0 : x1)) return ~cur;
		return cur;
	endfunction
	task automatic chk_stat(input string what, input logic [31:0] exp);
		apb(1'b0, `RCSW_ADDR_STAT, 32'h00000000);
		check(what, rd, exp);
		check("active pin", {31'h00000000, act}, {31'h00000000, exp[0]});
	endtask
	task automatic watch();
		logic p, t;
		np = 0;
		nt = 0;
		for (int k = 0; k < 80; k++) begin
			p = pll_ref;
			t = tq[0];
			@(posedge mclk);
			#1;
			np += int'(pll_ref !== p);
			nt += int'(tq[0] !== t);
		end
	endtask
	task automatic set_src(input logic a, b);
		@(posedge mclk);
		run_a <= a;
		run_b <= b;
		// A source that is already stopped keeps its level, so no stray edge appears.
		if (run_a)
			stk_a <= 1'($urandom);
		if (run_b)
			stk_b <= 1'($urandom);
		repeat (60) @(posedge mclk);
	endtask
	// ----------------------------------------------------------------------
	// Clock and main sequence
	// ----------------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{run_a, run_b, stk_a, stk_b} = 4'hC;
		rst = 1'b1;
		void'($urandom(32'hC572));
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		apb(1'b0, `RCSW_ADDR_CTRL, 32'h00000000);
		check("ctrl reset", rd, {28'h0000000, `RCSW_CTRL_RST});
		chk_stat("stat reset", 32'h00000000);
		apb(1'b0, {10'($urandom_range(2, 1023)), 2'b00}, 32'h00000000);
		check("unmapped err", {31'h00000000, err}, 32'h00000001);
		$display("test reset and map done");
		for (int r = 0; r < 2; r++) begin
			s = (r == 0) ? 1'($urandom) : ~s;
			// Lock in manual mode, release to automatic, then run the init event.
			apb(1'b1, `RCSW_ADDR_CTRL, ctl(s, 1'b1, 1'b1, 1'b1));
			apb(1'b1, `RCSW_ADDR_CTRL, ctl(s, 1'b0, 1'b1, 1'b1));
			apb(1'b1, `RCSW_ADDR_CTRL, ctl(s, 1'b0, 1'b1, 1'b0));
			repeat (2) @(posedge mclk);
			exp_act = s;
			chk_stat("init", stat(s, 1'b0, 1'b0, s));
			foreach (steps[i]) begin
				ra = s ? steps[i][0] : steps[i][1];
				rb = s ? steps[i][1] : steps[i][0];
				set_src(ra, rb);
				exp_act = next_act(exp_act, 1'b0, s, ~ra, ~rb);
				chk_stat("auto", stat(exp_act, ~ra, ~rb, s));
				watch();
				check("pll runs", 32'(np > 0), 32'(exp_act ? rb : ra));
			end
			$display("test automatic round %0d done", r);
		end
		// Manual hold: follows the select input and ignores a failure.
		for (int v = 0; v < 2; v++) begin
			apb(1'b1, `RCSW_ADDR_CTRL, ctl(v[0], 1'b1, 1'b1, 1'b0));
			repeat (4) @(posedge mclk);
			check("manual sel", {31'h00000000, act}, v);
			set_src(v[0], ~v[0]);
			chk_stat("manual hold", stat(v[0], ~v[0], v[0], s));
			set_src(1'b1, 1'b1);
		end
		$display("test manual done");
		apb(1'b1, `RCSW_ADDR_CTRL, ctl(1'b0, 1'b1, 1'b0, 1'b0));
		watch();
		check("true held", {26'h0000000, tq}, 32'h00000000);
		check("inverted held", {26'h0000000, iq}, 32'h0000003F);
		apb(1'b1, `RCSW_ADDR_CTRL, ctl(1'b0, 1'b1, 1'b1, 1'b0));
		watch();
		check("dividers run", 32'(nt > 0), 32'h00000001);
		check("outputs paired", {26'h0000000, iq}, {26'h0000000, ~tq});
		$display("test divider reset done");
		give_verdict();
	end
endmodule // rcsw_tb_top
